// ===== rtl/sdsi_regs.v
// Data, status and interrupt-mask registers of the serial interface
`timescale 1ns/1ps
`default_nettype none
`include "sdsi_consts.vh"

module sdsi_regs #(
  parameter AW = 8
) (
  input  wire          clk,               // System clock, 100 MHz
  input  wire          rst_n,             // Async reset, active low
  // AXI4-Lite slave
  input  wire [AW-1:0] s_axi_awaddr,      // Write address
  input  wire          s_axi_awvalid,     // Write address valid
  output wire          s_axi_awready,     // Write address ready
  input  wire [31:0]   s_axi_wdata,       // Write data
  input  wire [3:0]    s_axi_wstrb,       // Write byte strobes
  input  wire          s_axi_wvalid,      // Write data valid
  output wire          s_axi_wready,      // Write data ready
  output wire [1:0]    s_axi_bresp,       // Write response
  output wire          s_axi_bvalid,      // Write response valid
  input  wire          s_axi_bready,      // Write response ready
  input  wire [AW-1:0] s_axi_araddr,      // Read address
  input  wire          s_axi_arvalid,     // Read address valid
  output wire          s_axi_arready,     // Read address ready
  output wire [31:0]   s_axi_rdata,       // Read data
  output wire [1:0]    s_axi_rresp,       // Read response
  output wire          s_axi_rvalid,      // Read data valid
  input  wire          s_axi_rready,      // Read data ready
  // Serializer side, same clock
  input  wire          ser_rx_load,       // Pulse: character received
  input  wire [15:0]   ser_rx_data,       // Received character
  input  wire          ser_tx_take,       // Pulse: serializer takes data
  input  wire          ser_char_done,     // Pulse: character shifted out
  input  wire          ser_idle,          // Shifter empty, delays over
  input  wire          ser_mode_fault,    // Pulse: mode fault seen
  output wire          tx_pending,        // Holding register has data
  output wire [15:0]   tx_outgoing_word,  // Character for the shifter
  output wire [3:0]    chip_select_lines, // Select pins, active low
  // DMA counter indications, same clock
  input  wire          rx_cnt_zero,       // Receive counter is zero
  input  wire          rx_next_zero,      // Receive next counter zero
  input  wire          tx_cnt_zero,       // Transmit counter is zero
  input  wire          tx_next_zero,      // Transmit next counter zero
  input  wire          rx_cnt_write,      // Pulse: a receive counter written
  input  wire          tx_cnt_write,      // Pulse: a transmit counter written
  // Pin and interrupt
  input  wire          slave_select_input, // Slave-select pin, async
  output wire          irq                // Interrupt, active high
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg          aw_hold_r;
  reg [AW-1:0] awaddr_r;
  reg          w_hold_r;
  reg [31:0]   wdata_r;
  reg [3:0]    wstrb_r;
  reg          bvalid_r;
  reg [1:0]    bresp_r;
  reg          rvalid_r;
  reg [1:0]    rresp_r;
  reg [31:0]   rdata_r;
  reg [31:0]   rdata_nxt;
  reg          rmap_nxt;
  reg          wmap_nxt;
  reg          enabled_r;
  reg [31:0]   mode_r;
  reg [15:0]   rx_data_r;
  reg [3:0]    rx_pcs_r;
  reg [15:0]   tx_data_r;
  reg [3:0]    tx_pcs_r;
  reg          tx_last_r;
  reg [3:0]    cur_sel_r;
  reg          cur_last_r;
  reg          cs_active_r;
  reg [3:0]    cs_lines_r;
  reg [`SDSI_NFLAGS-1:0] flags_r;
  reg [`SDSI_NFLAGS-1:0] mask_r;
  reg          rx_zero_d_r;
  reg          tx_zero_d_r;
  reg          nss_d_r;
  reg          irq_r;
  wire         nss_sync;
  wire [3:0]   sel_lines;
  wire [31:0]  wbyte;
  wire [31:0]  wd;
  wire         wr_fire;
  wire         rd_fire;
  wire [7:0]   waddr;
  wire [7:0]   raddr;
  wire         wr_ctl;
  wire         wr_tx;
  wire         wr_iset;
  wire         wr_iclr;
  wire         rd_rx;
  wire         rd_st;
  wire         en_cmd;
  wire         dis_cmd;
  wire         master;
  wire         varsel;
  wire [4:0]   char_len;
  wire [15:0]  rx_mask;
  wire [`SDSI_NFLAGS-1:0] status;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign wr_fire       = aw_hold_r && w_hold_r && !bvalid_r;
  assign waddr         = {awaddr_r[7:2], 2'b00};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= {AW{1'b0}};
      w_hold_r  <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `SDSI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wmap_nxt ? `SDSI_RESP_OKAY : `SDSI_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Byte strobes gate which bits of a write take effect
  assign wbyte = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                  {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign wd    = wdata_r & wbyte;

  // Mapped write offsets; writes to read-only offsets still answer OKAY
  always @* begin
    case (waddr)
      `SDSI_OFF_CONTROL, `SDSI_OFF_MODE, `SDSI_OFF_RXHOLD,
      `SDSI_OFF_TXHOLD, `SDSI_OFF_STATUS, `SDSI_OFF_IEN_SET,
      `SDSI_OFF_IEN_CLR, `SDSI_OFF_IMASK: wmap_nxt = 1'b1;
      default: wmap_nxt = 1'b0;
    endcase
  end

  assign wr_ctl  = wr_fire && (waddr == `SDSI_OFF_CONTROL);
  assign wr_tx   = wr_fire && (waddr == `SDSI_OFF_TXHOLD);
  assign wr_iset = wr_fire && (waddr == `SDSI_OFF_IEN_SET);
  assign wr_iclr = wr_fire && (waddr == `SDSI_OFF_IEN_CLR);
  assign en_cmd  = wr_ctl && wd[`SDSI_CTL_ENABLE];
  // Enable and disable together leaves the block disabled
  assign dis_cmd = wr_ctl && wd[`SDSI_CTL_DISABLE];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel: data one cycle after the address is taken
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign rd_fire       = s_axi_arvalid && !rvalid_r;
  assign raddr         = {s_axi_araddr[7:2], 2'b00};
  assign rd_rx         = rd_fire && (raddr == `SDSI_OFF_RXHOLD);
  assign rd_st         = rd_fire && (raddr == `SDSI_OFF_STATUS);

  // Read mux; write-only registers read as zero
  always @* begin
    rdata_nxt = 32'h0000_0000;
    rmap_nxt  = 1'b1;
    case (raddr)
      `SDSI_OFF_CONTROL, `SDSI_OFF_TXHOLD,
      `SDSI_OFF_IEN_SET, `SDSI_OFF_IEN_CLR: rdata_nxt = 32'h0000_0000;
      `SDSI_OFF_MODE: rdata_nxt = mode_r;
      `SDSI_OFF_RXHOLD: begin
        rdata_nxt[`SDSI_DATA_HI:0]            = rx_data_r;
        rdata_nxt[`SDSI_PCS_HI:`SDSI_PCS_LO] = rx_pcs_r;
      end
      `SDSI_OFF_STATUS: begin
        rdata_nxt[`SDSI_NFLAGS-1:0]  = status;
        rdata_nxt[`SDSI_ST_ENABLED]  = enabled_r;
      end
      `SDSI_OFF_IMASK: rdata_nxt[`SDSI_NFLAGS-1:0] = mask_r;
      default: rmap_nxt = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `SDSI_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rmap_nxt ? `SDSI_RESP_OKAY : `SDSI_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable state and mode settings
  assign master   = mode_r[`SDSI_MODE_MASTER];
  assign varsel   = mode_r[`SDSI_MODE_VARSEL];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enabled_r <= 1'b0;
      mode_r    <= 32'h0000_0000;
    end else begin
      if (dis_cmd) begin
        enabled_r <= 1'b0;
      end else if (en_cmd) begin
        enabled_r <= 1'b1;
      end
      if (wr_fire && (waddr == `SDSI_OFF_MODE)) begin
        mode_r <= wd & `SDSI_MODE_WMASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive holding register: only the configured character bits survive
  assign char_len = (mode_r[`SDSI_MODE_BITS_HI:`SDSI_MODE_BITS_LO] > 4'h8)
                    ? `SDSI_CHAR_MAX
                    : `SDSI_CHAR_BASE
                      + {1'b0, mode_r[`SDSI_MODE_BITS_HI:`SDSI_MODE_BITS_LO]};

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_rxmask
      localparam [4:0] IDX = gi;
      assign rx_mask[gi] = (char_len > IDX);
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_r <= 16'h0000;
      rx_pcs_r  <= 4'h0;
    end else if (ser_rx_load) begin
      rx_data_r <= ser_rx_data & rx_mask;
      rx_pcs_r  <= master ? cs_lines_r : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding register and chip-select control
  assign tx_pending       = enabled_r && !flags_r[`SDSI_ST_TRANSMISSION_IDLE_FLAG];
  assign tx_outgoing_word = tx_data_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_r   <= 16'h0000;
      tx_pcs_r    <= 4'hF;
      tx_last_r   <= 1'b0;
      cur_sel_r   <= 4'hF;
      cur_last_r  <= 1'b0;
      cs_active_r <= 1'b0;
    end else begin
      if (wr_tx) begin
        tx_data_r <= wd[`SDSI_DATA_HI:0];
        tx_pcs_r  <= wd[`SDSI_PCS_HI:`SDSI_PCS_LO];
        tx_last_r <= wd[`SDSI_LAST_BIT];
      end
      if (!enabled_r) begin
        cs_active_r <= 1'b0;
      end else if (ser_tx_take && tx_pending) begin
        // Select field ignored unless per-character selection is on
        cur_sel_r   <= varsel ? tx_pcs_r
                              : mode_r[`SDSI_MODE_PCS_HI:`SDSI_MODE_PCS_LO];
        cur_last_r  <= varsel && tx_last_r;
        cs_active_r <= master;
      end else if (ser_char_done) begin
        // Final character drops the select even when keep-select is set
        if (!mode_r[`SDSI_MODE_KEEPSEL] || cur_last_r) begin
          cs_active_r <= 1'b0;
        end
      end
    end
  end

  sdsi_cs_decode u_dec (
    .sel     (cur_sel_r),
    .ext_dec (mode_r[`SDSI_MODE_EXTDEC]),
    .lines   (sel_lines)
  );

  // Registered pins; inactive lines sit high
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_lines_r <= 4'hF;
    end else begin
      cs_lines_r <= cs_active_r ? sel_lines : 4'hF;
    end
  end
  assign chip_select_lines = cs_lines_r;

  ////////////////////////////////////////////////////////////////////////////
  // Slave-select pin synchronised before edge detection
  sdsi_sync #(.W(1)) u_nss (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (slave_select_input),
    .q     (nss_sync)
  );

  // Delayed copies for edge detection
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nss_d_r     <= 1'b1;
      rx_zero_d_r <= 1'b0;
      tx_zero_d_r <= 1'b0;
    end else begin
      nss_d_r     <= nss_sync;
      rx_zero_d_r <= rx_cnt_zero;
      tx_zero_d_r <= tx_cnt_zero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags, sticky but for the two all-done levels; a set beats a same-cycle clear, save a holding write on idle and a disable on transmission idle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= {`SDSI_NFLAGS{1'b0}};
    end else begin
      if (ser_rx_load) begin
        flags_r[`SDSI_ST_RXFULL] <= 1'b1;
      end else if (rd_rx) begin
        flags_r[`SDSI_ST_RXFULL] <= 1'b0;
      end
      if (!enabled_r && !en_cmd) begin
        flags_r[`SDSI_ST_TRANSMISSION_IDLE_FLAG] <= 1'b0;
      end else if (dis_cmd) begin
        flags_r[`SDSI_ST_TRANSMISSION_IDLE_FLAG] <= 1'b0;
      end else if (en_cmd && !enabled_r) begin
        flags_r[`SDSI_ST_TRANSMISSION_IDLE_FLAG] <= 1'b1;
      end else if (ser_tx_take && tx_pending) begin
        flags_r[`SDSI_ST_TRANSMISSION_IDLE_FLAG] <= 1'b1;
      end else if (wr_tx) begin
        flags_r[`SDSI_ST_TRANSMISSION_IDLE_FLAG] <= 1'b0;
      end
      if (ser_mode_fault) begin
        flags_r[`SDSI_ST_MODE_FAULT_FLAG] <= 1'b1;
      end else if (rd_st) begin
        flags_r[`SDSI_ST_MODE_FAULT_FLAG] <= 1'b0;
      end
      // Second load before the receive register is read
      if (ser_rx_load && flags_r[`SDSI_ST_RXFULL] && !rd_rx) begin
        flags_r[`SDSI_ST_OVR] <= 1'b1;
      end else if (rd_st) begin
        flags_r[`SDSI_ST_OVR] <= 1'b0;
      end
      if (rx_cnt_zero && !rx_zero_d_r) begin
        flags_r[`SDSI_ST_RX_DMA_COUNT_DONE] <= 1'b1;
      end else if (rx_cnt_write) begin
        flags_r[`SDSI_ST_RX_DMA_COUNT_DONE] <= 1'b0;
      end
      if (tx_cnt_zero && !tx_zero_d_r) begin
        flags_r[`SDSI_ST_TX_DMA_COUNT_DONE] <= 1'b1;
      end else if (tx_cnt_write) begin
        flags_r[`SDSI_ST_TX_DMA_COUNT_DONE] <= 1'b0;
      end
      flags_r[`SDSI_ST_RX_DMA_ALL_DONE] <= rx_cnt_zero && rx_next_zero;
      flags_r[`SDSI_ST_TX_DMA_ALL_DONE] <= tx_cnt_zero && tx_next_zero;
      if (nss_sync && !nss_d_r) begin
        flags_r[`SDSI_ST_SLAVE_SELECT_RISE_FLAG] <= 1'b1;
      end else if (rd_st) begin
        flags_r[`SDSI_ST_SLAVE_SELECT_RISE_FLAG] <= 1'b0;
      end
      // Idle needs an idle shifter and, while enabled, an empty holding register
      if (wr_tx) begin
        flags_r[`SDSI_ST_IDLE] <= 1'b0;
      end else if (ser_idle && (flags_r[`SDSI_ST_TRANSMISSION_IDLE_FLAG] || !enabled_r))
      begin
        flags_r[`SDSI_ST_IDLE] <= 1'b1;
      end
    end
  end
  assign status = flags_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt mask: set and clear through separate write-only registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= {`SDSI_NFLAGS{1'b0}};
    end else if (wr_iset) begin
      mask_r <= mask_r | wd[`SDSI_NFLAGS-1:0];
    end else if (wr_iclr) begin
      mask_r <= mask_r & ~wd[`SDSI_NFLAGS-1:0];
    end
  end

  // One registered interrupt line from masked flags
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(flags_r & mask_r);
    end
  end
  assign irq = irq_r;

endmodule // sdsi_regs
`default_nettype wire

// ===== rtl/sdsi_consts.vh
// Register map and field positions of the data/status block
`ifndef SDSI_CONSTS_VH
`define SDSI_CONSTS_VH
// Byte offsets on the register bus
`define SDSI_OFF_CONTROL   8'h00
`define SDSI_OFF_MODE      8'h04
`define SDSI_OFF_RXHOLD    8'h08
`define SDSI_OFF_TXHOLD    8'h0C
`define SDSI_OFF_STATUS    8'h10
`define SDSI_OFF_IEN_SET   8'h14
`define SDSI_OFF_IEN_CLR   8'h18
`define SDSI_OFF_IMASK     8'h1C
// Control register command bits
`define SDSI_CTL_ENABLE    0
`define SDSI_CTL_DISABLE   1
// Mode register fields
`define SDSI_MODE_MASTER   0
`define SDSI_MODE_VARSEL   1
`define SDSI_MODE_EXTDEC   2
`define SDSI_MODE_KEEPSEL  3
`define SDSI_MODE_BITS_LO  8
`define SDSI_MODE_BITS_HI  11
`define SDSI_MODE_PCS_LO   16
`define SDSI_MODE_PCS_HI   19
`define SDSI_MODE_WMASK    32'h000F_0F0F
// Holding register fields
`define SDSI_DATA_HI       15
`define SDSI_PCS_LO        16
`define SDSI_PCS_HI        19
`define SDSI_LAST_BIT      24
// Status bit positions
`define SDSI_ST_RXFULL     0
`define SDSI_ST_TRANSMISSION_IDLE_FLAG    1
`define SDSI_ST_MODE_FAULT_FLAG       2
`define SDSI_ST_OVR        3
`define SDSI_ST_RX_DMA_COUNT_DONE      4
`define SDSI_ST_TX_DMA_COUNT_DONE      5
`define SDSI_ST_RX_DMA_ALL_DONE     6
`define SDSI_ST_TX_DMA_ALL_DONE     7
`define SDSI_ST_SLAVE_SELECT_RISE_FLAG       8
`define SDSI_ST_IDLE       9
`define SDSI_ST_ENABLED    16
`define SDSI_NFLAGS        10
// Character length base and maximum
`define SDSI_CHAR_BASE     5'h08
`define SDSI_CHAR_MAX      5'h10
// Bus responses
`define SDSI_RESP_OKAY     2'b00
`define SDSI_RESP_SLVERR   2'b10
`endif

// ===== rtl/sdsi_sync.v
// Two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sdsi_sync #(
  parameter W = 1
) (
  input  wire         clk,    // System clock
  input  wire         rst_n,  // Async reset, active low
  input  wire [W-1:0] d,      // Asynchronous level
  output wire [W-1:0] q       // Synchronised level
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule // sdsi_sync
`default_nettype wire

// ===== rtl/sdsi_cs_decode.v
// Chip-select pattern generator: direct one-low wiring or external decoder
`timescale 1ns/1ps
`default_nettype none
module sdsi_cs_decode (
  input  wire [3:0] sel,      // Peripheral select value
  input  wire       ext_dec,  // External 4-to-16 decoder fitted
  output reg  [3:0] lines     // Chip-select line pattern
);
  // Without the external decoder the lowest zero wins; all-ones selects nobody
  always @* begin
    if (ext_dec) begin
      lines = sel;
    end else if (!sel[0]) begin
      lines = 4'b1110;
    end else if (!sel[1]) begin
      lines = 4'b1101;
    end else if (!sel[2]) begin
      lines = 4'b1011;
    end else if (!sel[3]) begin
      lines = 4'b0111;
    end else begin
      lines = 4'b1111;
    end
  end
endmodule // sdsi_cs_decode
`default_nettype wire

// ===== test/sdsi_regs_assertions.sv
// Concurrent checks on the data/status register block ports
`timescale 1ns/1ps
`default_nettype none
`include "sdsi_consts.vh"
module sdsi_chk #(
  parameter AW = 8
) (
  input wire          clk,
  input wire          rst_n,
  input wire [AW-1:0] s_axi_awaddr,
  input wire          s_axi_awvalid,
  input wire          s_axi_awready,
  input wire [31:0]   s_axi_wdata,
  input wire          s_axi_wvalid,
  input wire          s_axi_wready,
  input wire          s_axi_bvalid,
  input wire [AW-1:0] s_axi_araddr,
  input wire          s_axi_arvalid,
  input wire          s_axi_arready,
  input wire [31:0]   s_axi_rdata,
  input wire [1:0]    s_axi_rresp,
  input wire          s_axi_rvalid,
  input wire          s_axi_rready,
  input wire          ser_tx_take,
  input wire          tx_pending,
  input wire          irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Handshakes completing at this edge
  wire ar_t = s_axi_arvalid && s_axi_arready;
  wire wr_t = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  ////////////////////////////////////////////////////////////////////////////
  AST_B_RESP: assert property (wr_t |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  AST_R_RESP: assert property (ar_t |-> ##[1:2] s_axi_rvalid)
    else $error("read response missing");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after handshake");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  AST_RD_ERR: assert property (ar_t && s_axi_araddr > 8'h1C |->
    ##[1:2] (s_axi_rvalid && s_axi_rresp == `SDSI_RESP_SLVERR))
    else $error("unmapped read not refused");
  AST_ST_RSV: assert property (ar_t && s_axi_araddr == `SDSI_OFF_STATUS |->
    ##[1:2] (s_axi_rvalid && s_axi_rdata[31:17] == 15'h0
    && s_axi_rdata[15:10] == 6'h0)) else $error("status spare bits set");
  // Take empties the holding register when no write lands meanwhile
  AST_TX_TAKE: assert property (ser_tx_take && tx_pending && !s_axi_awvalid
    && !s_axi_bvalid |=> !tx_pending) else $error("holding still full");
  AST_IRQ_OFF: assert property (wr_t && s_axi_wdata[9:0] == 10'h3FF
    && s_axi_awaddr == `SDSI_OFF_IEN_CLR |-> ##[2:4] !irq)
    else $error("interrupt high with all masks cleared");
  // Main scenarios reached
  COV_TAKE: cover property (ser_tx_take && tx_pending);
  COV_ERR: cover property (s_axi_rvalid && s_axi_rresp == `SDSI_RESP_SLVERR);
  COV_IRQ: cover property ($rose(irq));
endmodule // sdsi_chk
bind sdsi_regs sdsi_chk #(.AW(AW)) chk_u (.clk, .rst_n, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ser_tx_take, .tx_pending, .irq);
`default_nettype wire

// ===== test/sdsi_ser_model.sv
// Serializer-side partner: strobes, received characters, select pin
`timescale 1ns/1ps
`default_nettype none
module sdsi_ser_model (
  input  wire logic        clk,                // System clock
  output var  logic        ser_rx_load,        // Character received
  output var  logic [15:0] ser_rx_data,        // Received character
  output var  logic        ser_tx_take,        // Holding register taken
  output var  logic        ser_char_done,      // Character shifted out
  output var  logic        ser_idle,           // Shifter empty
  output var  logic        ser_mode_fault,     // Mode fault seen
  output var  logic        slave_select_input  // Select pin
);
  // Pin idles low so reset release shows no false rising edge
  initial begin
    {ser_rx_load, ser_tx_take, ser_char_done, ser_mode_fault} = 4'h0;
    {ser_idle, slave_select_input, ser_rx_data} = 18'h2_0000;
  end
  // One-cycle character load; data shows its inverse once released
  task automatic rx(input logic [15:0] d);
    @(posedge clk);
    ser_rx_load <= 1'b1;
    ser_rx_data <= d;
    @(posedge clk);
    ser_rx_load <= 1'b0;
    ser_rx_data <= ~d;
  endtask
  // One-cycle strobe: bit 0 take, bit 1 done, bit 2 fault; busy take..done
  task automatic strobe(input logic [2:0] m);
    @(posedge clk);
    {ser_mode_fault, ser_char_done, ser_tx_take} <= m;
    if (m[0]) ser_idle <= 1'b0;
    @(posedge clk);
    {ser_mode_fault, ser_char_done, ser_tx_take} <= 3'h0;
    if (m[1]) ser_idle <= 1'b1;
  endtask
  // Select pulse long enough to cross the synchroniser
  task automatic nss_rise();
    @(posedge clk);
    slave_select_input <= 1'b1;
    repeat (8) @(posedge clk);
    slave_select_input <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule // sdsi_ser_model
`default_nettype wire

// ===== test/testbench.sv
// Register-level bench for the data/status block with serializer model
`timescale 1ns/1ps
`default_nettype none
`include "sdsi_consts.vh"
module testbench;
  logic clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_arvalid = 0, s_axi_bready = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rdv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] rsp;
  logic rx_cnt_zero = 0, rx_next_zero = 0, tx_cnt_zero = 0, tx_next_zero = 0;
  logic rx_cnt_write = 0, tx_cnt_write = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire tx_pending, irq, ser_rx_load, ser_tx_take, ser_char_done, ser_idle;
  wire ser_mode_fault, slave_select_input;
  wire [1:0] s_axi_rresp, s_axi_bresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] tx_outgoing_word, ser_rx_data;
  wire [3:0] chip_select_lines;
  int n_errors = 0, checked = 0;
  // Per-case mode, transmit word and expected select pattern
  logic [31:0] md [5] = '{32'h0000_0003, 32'h0000_0003, 32'h0000_000B,
                          32'h0000_0007, 32'h0001_0001};
  logic [31:0] tw [5] = '{32'h0000_01A5, 32'h0001_005A, 32'h0103_00C3,
                          32'h0005_0011, 32'h0000_0022};
  logic [3:0] ln [5] = '{4'hE, 4'hD, 4'hB, 4'h5, 4'hD};
  sdsi_regs #(.AW(8)) dut_u (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ser_rx_load, .ser_rx_data, .ser_tx_take, .ser_char_done,
    .ser_idle, .ser_mode_fault, .tx_pending, .tx_outgoing_word,
    .chip_select_lines, .rx_cnt_zero, .rx_next_zero, .tx_cnt_zero,
    .tx_next_zero, .rx_cnt_write, .tx_cnt_write, .slave_select_input, .irq);
  sdsi_ser_model ser_u (.clk, .ser_rx_load, .ser_rx_data, .ser_tx_take,
    .ser_char_done, .ser_idle, .ser_mode_fault, .slave_select_input);
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
  endtask
  task automatic stop_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog: the sequence needs a few hundred cycles
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(`SDSI_OFF_STATUS, 32'h0000_0200);
    wr(`SDSI_OFF_CONTROL, 32'h0000_0001);
    rc(`SDSI_OFF_STATUS, 32'h0001_0202);
    // Select decoding per mode; 1111 is never requested
    for (int i = 0; i < 5; i++) begin
      wr(`SDSI_OFF_MODE, md[i]);
      wr(`SDSI_OFF_TXHOLD, tw[i]);
      chk(tx_outgoing_word, tw[i][15:0]);
      rc(`SDSI_OFF_STATUS, 32'h0001_0000);
      ser_u.strobe(3'b001);
      repeat (3) @(posedge clk);
      chk(chip_select_lines, ln[i]);
      rc(`SDSI_OFF_STATUS, 32'h0001_0002);
      if (i == 0) begin
        ser_u.rx(16'hFFFF);
        rc(`SDSI_OFF_RXHOLD, 32'h000E_00FF);
      end
      ser_u.strobe(3'b010);
      repeat (3) @(posedge clk);
      if (i == 2) chk(chip_select_lines, 4'hF);
    end
    // Two loads unread in slave mode with 16-bit characters
    wr(`SDSI_OFF_MODE, 32'h0000_0800);
    ser_u.rx(16'h1234);
    ser_u.rx(16'hBEEF);
    rc(`SDSI_OFF_STATUS, 32'h0001_020B);
    rc(`SDSI_OFF_STATUS, 32'h0001_0203);
    rc(`SDSI_OFF_RXHOLD, 32'h0000_BEEF);
    ser_u.strobe(3'b100);
    ser_u.nss_rise();
    rc(`SDSI_OFF_STATUS, 32'h0001_0306);
    rc(`SDSI_OFF_STATUS, 32'h0001_0202);
    // Counter indications, then counter writes with counters nonzero
    {rx_cnt_zero, rx_next_zero, tx_cnt_zero, tx_next_zero} <= 4'hF;
    repeat (3) @(posedge clk);
    rc(`SDSI_OFF_STATUS, 32'h0001_02F2);
    {rx_cnt_zero, tx_cnt_zero, rx_cnt_write, tx_cnt_write} <= 4'h3;
    @(posedge clk);
    {rx_cnt_write, tx_cnt_write} <= 2'b00;
    repeat (2) @(posedge clk);
    rc(`SDSI_OFF_STATUS, 32'h0001_0202);
    // Interrupt masking
    s_axi_wstrb <= 4'h1;
    wr(`SDSI_OFF_IEN_SET, 32'h0000_03FF);
    rc(`SDSI_OFF_IMASK, 32'h0000_00FF);
    s_axi_wstrb <= 4'hF;
    wr(`SDSI_OFF_IEN_SET, 32'h0000_03FF);
    rc(`SDSI_OFF_IMASK, 32'h0000_03FF);
    chk(irq, 1'b1);
    wr(`SDSI_OFF_IEN_CLR, 32'h0000_03FE);
    rc(`SDSI_OFF_IMASK, 32'h0000_0001);
    chk(irq, 1'b0);
    ser_u.rx(16'h0055);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    rc(`SDSI_OFF_RXHOLD, 32'h0000_0055);
    wr(`SDSI_OFF_IEN_CLR, 32'h0000_03FF);
    chk(irq, 1'b0);
    wr(`SDSI_OFF_CONTROL, 32'h0000_0003);
    rc(`SDSI_OFF_STATUS, 32'h0000_0200);
    rd(8'h40);
    chk(rsp, `SDSI_RESP_SLVERR);
    wr(8'h40, 32'h0000_0000);
    chk(s_axi_bresp, `SDSI_RESP_SLVERR);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
